// [hdl/event_vector_unit.v]
// event ranking, vector redirect and reset state for the processor core
// Contract
// - priority: reset, fault, non-maskable break, break, interrupt, user exception
// - each vector spans two word slots for prefix plus absolute branch
// - vectors are base parameter plus fixed offset, base default zero
// - system or debugger reset flushes, fetches base+0x0, records no return
// - user exception goes to base+0x8/0xC, return in chosen register
// - interrupt goes to base+0x10/0x14, return in register fourteen
// - low-latency mode branches to controller-supplied handler address
// - all breaks go to base+0x18/0x1C, return in register sixteen
// - fault goes to base+0x20/0x24, return in r17 or branch target
// - every event clears the load-reserve reservation flag
// - both reset inputs are active high
// - reset leaves general registers and caches untouched
// - reset fetch does not wait for outstanding bus transactions
// - reset loads machine state bits 2,4,6,8,9,10 from parameters
// - reset clears fault address, fault status, float status
// - reset clears process id, zone protect, translation index
// - no hardware page access or modification tracking
// - fault flushes pipeline and kills execute-stage instruction
// - non-translation fault in delay slot sets delay-slot flag
`timescale 1ns/100ps
`include "event_vector_consts.vh"
module event_vector_unit #(
   parameter ADDR_W = 32,
   parameter [ADDR_W-1:0] vector_base_param = 32'h00000000,
   parameter reset_intr_enable_init = 0,
   parameter reset_break_active_init = 0,
   parameter reset_icache_on_init = 0,
   parameter reset_dcache_on_init = 0,
   parameter reset_fault_enable_init = 0,
   parameter reset_fault_active_init = 0
) (
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // event sources
   input wire sys_reset,
   input wire dbg_reset,
   input wire fault_req,
   input wire fault_is_xlat,
   input wire fault_in_delay_slot,
   input wire [ADDR_W-1:0] fault_resume_pc,
   input wire [ADDR_W-1:0] fault_next_pc,
   input wire [ADDR_W-1:0] fault_data_addr,
   input wire nm_break_req,
   input wire break_req,
   input wire [ADDR_W-1:0] break_return_pc,
   input wire intr_req,
   input wire [ADDR_W-1:0] intr_return_pc,
   input wire [ADDR_W-1:0] intr_handler_addr,
   input wire user_exc_req,
   input wire [4:0] user_ret_sel,
   input wire [ADDR_W-1:0] user_return_pc,
   input wire reserve_set,
   // pipeline side
   output reg redirect,
   output reg [ADDR_W-1:0] fetch_addr,
   output reg flush,
   output reg kill_execute,
   output reg ret_we,
   output reg [4:0] ret_sel,
   output reg [ADDR_W-1:0] ret_data,
   output reg use_branch_target,
   output reg reserve_flag,
   output reg [31:0] machine_state_reg,
   output reg [5:0] last_event
);
   // ***************************************************************
   // reset value of machine state
   // ***************************************************************
   localparam [31:0] MS_RESET =
      ((reset_intr_enable_init & 1) << `MS_IE) |
      ((reset_break_active_init & 1) << `MS_BIP) |
      ((reset_icache_on_init & 1) << `MS_ICE) |
      ((reset_dcache_on_init & 1) << `MS_DCE) |
      ((reset_fault_enable_init & 1) << `MS_EE) |
      ((reset_fault_active_init & 1) << `MS_EIP);

   // vector address; offsets are small, sum is cut to address width
   function [ADDR_W-1:0] vec;
      input [7:0] ofs;
      begin
         vec = vector_base_param + {{(ADDR_W-8){1'b0}}, ofs};
      end
   endfunction

   // ***************************************************************
   // event class decode
   // ***************************************************************
   // both break kinds share one vector, one return register and one status bit
   function is_break;
      input [5:0] ev;
      begin
         is_break = (ev == `EV_NMBRK) || (ev == `EV_BRK);
      end
   endfunction

   // ***************************************************************
   // bus slave
   // ***************************************************************
   reg ctrl_ll_q;
   reg swrst_q;
   reg [31:0] fault_addr_reg;
   reg [31:0] fault_status_reg;
   reg [31:0] float_status_reg;
   reg [31:0] process_id_reg;
   reg [31:0] zone_protect_reg;
   reg [31:0] xlat_index_reg;
   reg [31:0] event_count_q;
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   wire access;
   wire [7:0] ofs;
   wire mapped;
   wire rd_hit;
   wire wr_hit;

   assign access = hsel & hready & htrans[1];
   assign ofs = haddr[7:0];
   assign mapped = (ofs <= `A_COUNT) && (ofs[1:0] == 2'b00);
   // only whole-word writes land; a narrower write is dropped rather than merged
   assign rd_hit = access & ~hwrite;
   assign wr_hit = access & hwrite & mapped & (hsize == `HSIZE_WORD);
   // single-cycle slave: never waits, never errors
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // read data registered at address phase; zero for unmapped offsets
   // a read in an event cycle returns the state from before the event
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `ZERO32;
      end else if (rd_hit) begin
         case (mapped ? ofs : 8'hFF)
            `A_CTRL: hrdata <= {30'h00000000, swrst_q, ctrl_ll_q};
            `A_STATE: hrdata <= machine_state_reg;
            `A_FADDR: hrdata <= fault_addr_reg;
            `A_FSTAT: hrdata <= fault_status_reg;
            `A_FLOAT: hrdata <= float_status_reg;
            `A_PID: hrdata <= process_id_reg;
            `A_ZONE: hrdata <= zone_protect_reg;
            `A_XIDX: hrdata <= xlat_index_reg;
            `A_LAST: hrdata <= {26'h0000000, last_event};
            `A_COUNT: hrdata <= event_count_q;
            default: hrdata <= `ZERO32;
         endcase
      end
   end

   // write address captured for the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= wr_hit;
         wr_addr_q <= ofs;
      end
   end

   // ***************************************************************
   // event selection
   // ***************************************************************
   wire any_reset;
   wire any_event;
   wire [5:0] pending;
   wire [5:0] grant;
   // software reset bit acts as a third active-high reset source
   assign any_reset = sys_reset | dbg_reset | swrst_q;
   assign pending = {user_exc_req, intr_req, break_req, nm_break_req, fault_req, any_reset};

   event_arbiter u_arb (
      .pending(pending),
      .grant(grant)
   );

   // one flag for redirect, flush and the reservation flag; the last_event update and the event count test |grant directly
   assign any_event = |grant;

   // ***************************************************************
   // redirect and return address, decided in the same clock
   // ***************************************************************
   // reset fetch is not held back by bus traffic: redirect is immediate
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         redirect <= 1'b0;
         fetch_addr <= vector_base_param;
         flush <= 1'b0;
         kill_execute <= 1'b0;
         ret_we <= 1'b0;
         ret_sel <= 5'h00;
         ret_data <= {ADDR_W{1'b0}};
         use_branch_target <= 1'b0;
         last_event <= `EV_NONE;
      end else begin
         redirect <= any_event;
         flush <= any_event;
         kill_execute <= 1'b0;
         ret_we <= 1'b0;
         use_branch_target <= 1'b0;
         if (|grant) begin
            last_event <= grant;
         end
         case (grant)
            `EV_RESET: begin
               fetch_addr <= vec(`OFS_RESET);
               // return write suppressed; general registers untouched
               ret_we <= 1'b0;
            end
            `EV_FAULT: begin
               fetch_addr <= vec(`OFS_FAULT);
               kill_execute <= 1'b1;
               // return register is named even when only the branch target is used
               ret_sel <= `RET_FAULT;
               if (fault_is_xlat) begin
                  ret_we <= 1'b1;
                  ret_data <= fault_resume_pc;
               end else if (fault_in_delay_slot) begin
                  // handler resumes from the branch target register
                  use_branch_target <= 1'b1;
               end else begin
                  ret_we <= 1'b1;
                  ret_data <= fault_next_pc;
               end
            end
            `EV_NMBRK, `EV_BRK: begin
               fetch_addr <= vec(`OFS_BREAK);
               ret_we <= 1'b1;
               ret_sel <= `RET_BREAK;
               ret_data <= break_return_pc;
            end
            // low-latency mode trusts the controller's address without a range check
            `EV_INTR: begin
               fetch_addr <= ctrl_ll_q ? intr_handler_addr : vec(`OFS_INTR);
               ret_we <= 1'b1;
               ret_sel <= `RET_INTR;
               ret_data <= intr_return_pc;
            end
            `EV_USER: begin
               fetch_addr <= vec(`OFS_USER);
               ret_we <= 1'b1;
               ret_sel <= user_ret_sel;
               ret_data <= user_return_pc;
            end
            default: begin
               // no event: the last vector stays on the fetch bus
               fetch_addr <= fetch_addr;
            end
         endcase
      end
   end

   // ***************************************************************
   // reservation flag
   // ***************************************************************
   // any event beats a same-cycle reserve; events are what clear it
   // hazard: a reserve taken in an event cycle is lost, so the store-conditional fails
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reserve_flag <= 1'b0;
      end else if (any_event) begin
         reserve_flag <= 1'b0;
      end else if (reserve_set) begin
         reserve_flag <= 1'b1;
      end
   end

   // ***************************************************************
   // architectural state and control
   // ***************************************************************
   // no page history bits exist here; software uses miss and storage faults
   // limitation: translation registers are plain storage, no lookup happens here
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         machine_state_reg <= MS_RESET;
         fault_addr_reg <= `ZERO32;
         fault_status_reg <= `ZERO32;
         float_status_reg <= `ZERO32;
         process_id_reg <= `ZERO32;
         zone_protect_reg <= `ZERO32;
         xlat_index_reg <= `ZERO32;
         ctrl_ll_q <= 1'b0;
         swrst_q <= 1'b0;
         event_count_q <= `ZERO32;
      end else if (grant == `EV_RESET) begin
         machine_state_reg <= MS_RESET;
         fault_addr_reg <= `ZERO32;
         fault_status_reg <= `ZERO32;
         float_status_reg <= `ZERO32;
         process_id_reg <= `ZERO32;
         zone_protect_reg <= `ZERO32;
         xlat_index_reg <= `ZERO32;
         // self-clearing so a software reset lasts one event
         swrst_q <= 1'b0;
         event_count_q <= event_count_q + 32'h00000001;
      end else begin
         if (|grant) begin
            event_count_q <= event_count_q + 32'h00000001;
         end
         if (grant == `EV_FAULT) begin
            fault_addr_reg <= fault_data_addr;
            fault_status_reg[`DS_BIT] <= fault_in_delay_slot & ~fault_is_xlat;
            machine_state_reg[`MS_EIP] <= 1'b1;
            machine_state_reg[`MS_EE] <= 1'b0;
         end else if (is_break(grant)) begin
            machine_state_reg[`MS_BIP] <= 1'b1;
         end else if (grant == `EV_INTR) begin
            machine_state_reg[`MS_IE] <= 1'b0;
         end
         // a write in a non-reset event cycle lands after the event's own updates, so software wins
         if (wr_pend_q) begin
            case (wr_addr_q)
               `A_CTRL: begin
                  ctrl_ll_q <= hwdata[`CTRL_LL];
                  swrst_q <= hwdata[`CTRL_SWRST];
               end
               `A_STATE: machine_state_reg <= hwdata;
               `A_FLOAT: float_status_reg <= hwdata;
               `A_PID: process_id_reg <= hwdata;
               `A_ZONE: zone_protect_reg <= hwdata;
               `A_XIDX: xlat_index_reg <= hwdata;
               default: ctrl_ll_q <= ctrl_ll_q;
            endcase
         end
      end
   end
endmodule // event_vector_unit

// [hdl/event_vector_consts.vh]
// constants for the event vector and reset unit
`ifndef EVENT_VECTOR_CONSTS_VH
`define EVENT_VECTOR_CONSTS_VH
// ***************************************************************
// vector offsets
// ***************************************************************
`define OFS_RESET 8'h00
`define OFS_USER 8'h08
`define OFS_INTR 8'h10
`define OFS_BREAK 8'h18
`define OFS_FAULT 8'h20
`define SLOT_STEP 8'h04
// ***************************************************************
// machine state bit positions
// ***************************************************************
`define MS_IE 2
`define MS_BIP 4
`define MS_ICE 6
`define MS_DCE 8
`define MS_EE 9
`define MS_EIP 10
// ***************************************************************
// event codes (one-hot, priority order)
// ***************************************************************
`define EV_NONE 6'h00
`define EV_RESET 6'h01
`define EV_FAULT 6'h02
`define EV_NMBRK 6'h04
`define EV_BRK 6'h08
`define EV_INTR 6'h10
`define EV_USER 6'h20
// ***************************************************************
// return register numbers
// ***************************************************************
`define RET_INTR 5'h0E
`define RET_BREAK 5'h10
`define RET_FAULT 5'h11
// ***************************************************************
// register bus map
// ***************************************************************
`define A_CTRL 8'h00
`define A_STATE 8'h04
`define A_FADDR 8'h08
`define A_FSTAT 8'h0C
`define A_FLOAT 8'h10
`define A_PID 8'h14
`define A_ZONE 8'h18
`define A_XIDX 8'h1C
`define A_LAST 8'h20
`define A_COUNT 8'h24
`define DS_BIT 12
`define CTRL_LL 0
`define CTRL_SWRST 1
`define ZERO32 32'h00000000
`define HSIZE_WORD 3'h2
`endif

// [hdl/event_arbiter.v]
// fixed-priority picker for pending processor events
`timescale 1ns/100ps
`include "event_vector_consts.vh"
module event_arbiter (
   input wire [5:0] pending,
   output reg [5:0] grant
);
   integer i;
   // ***************************************************************
   // lowest index wins
   // ***************************************************************
   // bit 0 is reset, bit 5 user exception
   always @* begin
      grant = `EV_NONE;
      for (i = 5; i >= 0; i = i - 1) begin
         if (pending[i]) begin
            grant = 6'h01 << i;
         end
      end
   end
endmodule // event_arbiter

// [tb/event_vector_unit_checker.sv]
// concurrent checks on the event vector unit ports
`timescale 1ns/100ps
`include "event_vector_consts.vh"
module event_vector_unit_checker #(
   parameter ADDR_W = 32,
   parameter [ADDR_W-1:0] vector_base_param = 32'h00000000
) (
   input wire hclk, hresetn, sys_reset, dbg_reset, fault_req, fault_is_xlat,
   input wire fault_in_delay_slot, nm_break_req, break_req, intr_req, user_exc_req,
   input wire [4:0] user_ret_sel, ret_sel,
   input wire [ADDR_W-1:0] intr_handler_addr, fetch_addr,
   input wire redirect, flush, kill_execute, ret_we, use_branch_target, reserve_flag,
   input wire [5:0] last_event
);
   // ****************
   // request decode
   // ****************
   wire rst = sys_reset | dbg_reset;
   wire hi = rst | fault_req;
   wire brk = nm_break_req | break_req;
   wire any_ev = hi | brk | intr_req | user_exc_req;
   wire bt = fault_in_delay_slot & ~fault_is_xlat;
   wire [ADDR_W-1:0] vb = vector_base_param;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // three checks for fault, one for each other event class, each tied to the winning request
   a_reset_vector: assert property (rst |=>
      redirect && fetch_addr == vb + `OFS_RESET && !ret_we && last_event == `EV_RESET)
      else $error("reset did not vector to base");
   a_fault_vector: assert property (fault_req && !rst |=>
      fetch_addr == vb + `OFS_FAULT && kill_execute && flush)
      else $error("fault vector or kill wrong");
   a_fault_return: assert property (fault_req && !rst && !bt |=>
      ret_we && ret_sel == `RET_FAULT) else $error("fault return register wrong");
   a_delay_slot: assert property (fault_req && !rst && bt |=>
      use_branch_target && !ret_we) else $error("delay slot fault not flagged");
   a_break_vector: assert property (brk && !hi |=>
      fetch_addr == vb + `OFS_BREAK && ret_we && ret_sel == `RET_BREAK)
      else $error("break vector wrong");
   a_intr_vector: assert property (intr_req && !hi && !brk |=> ret_we &&
      ret_sel == `RET_INTR && (fetch_addr == vb + `OFS_INTR ||
      fetch_addr == $past(intr_handler_addr))) else $error("interrupt vector wrong");
   a_user_vector: assert property (user_exc_req && !hi && !brk && !intr_req |=>
      fetch_addr == vb + `OFS_USER && ret_sel == $past(user_ret_sel))
      else $error("user exception vector wrong");
   a_reserve_clear: assert property (any_ev |=> !reserve_flag)
      else $error("reservation survived an event");
   a_one_clock: assert property (any_ev ##1 1'b1 |-> redirect && flush)
      else $error("redirect late");
   a_quiet_idle: assert property (!any_ev |=> !redirect && !ret_we)
      else $error("redirect without event");
   c_reset: cover property (rst ##1 redirect);
   c_slot: cover property (fault_req && bt);
   c_intr: cover property (intr_req && !hi && !brk);
endmodule // event_vector_unit_checker
bind event_vector_unit event_vector_unit_checker #(.ADDR_W(ADDR_W),
   .vector_base_param(vector_base_param)) u_chk (.hclk, .hresetn, .sys_reset, .dbg_reset,
   .fault_req, .fault_is_xlat, .fault_in_delay_slot, .nm_break_req, .break_req,
   .intr_req, .user_exc_req, .user_ret_sel, .ret_sel, .intr_handler_addr, .fetch_addr,
   .redirect, .flush, .kill_execute, .ret_we, .use_branch_target, .reserve_flag,
   .last_event);

// [tb/event_source_model.sv]
// far side model: reset sources and interrupt controller
`timescale 1ns/100ps
module event_source_model #(
   parameter [31:0] handler = 32'h0000_3000
) (
   input wire hclk, hresetn, intr_cmd,
   input wire [1:0] rst_cmd,
   output wire sys_reset, dbg_reset, intr_req,
   output wire [31:0] intr_handler_addr
);
   logic [4:0] cnt_q;
   logic [1:0] src_q;
   // a commanded reset is held sixteen cycles, the shortest advised
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 5'h00;
         src_q <= 2'h0;
      end else if (rst_cmd != 2'h0) begin
         cnt_q <= 5'h10;
         src_q <= rst_cmd;
      end else if (cnt_q != 5'h00) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end
   // both resets active high
   assign sys_reset = (cnt_q != 5'h00) && src_q[0];
   assign dbg_reset = (cnt_q != 5'h00) && src_q[1];
   // handler bus shows the inverse when idle so a stale sample cannot match
   assign intr_req = intr_cmd;
   assign intr_handler_addr = intr_cmd ? handler : ~handler;
endmodule // event_source_model

// [tb/event_vector_unit_tb.sv]
// self-checking bench for the event vector unit
`timescale 1ns/100ps
`include "event_vector_consts.vh"
module event_vector_unit_tb;
   localparam [31:0] base = 32'h0000_1000;
   localparam [31:0] hnd = 32'h0000_3000;
   localparam [31:0] ms_img = 32'h0000_0244; // ie, icache and fault enable set
   int ofs[5] = '{32, 24, 24, 16, 8};
   int rsel[5] = '{17, 16, 16, 14, 0};
   logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, intr_cmd = '0, reserve_set = '0;
   logic fault_req = '0, fault_is_xlat = '0, fault_in_delay_slot = '0, nm_break_req = '0;
   logic break_req = '0, user_exc_req = '0, ds = '0;
   logic [1:0] htrans = '0, rst_cmd = '0;
   logic [4:0] user_ret_sel = '0;
   logic [31:0] haddr = '0, hwdata = '0, pc = '0, rd, seed = 32'h0000_0017;
   wire hreadyout, hresp, sys_reset, dbg_reset, intr_req, redirect, flush, kill_execute;
   wire ret_we, use_branch_target, reserve_flag;
   wire [4:0] ret_sel;
   wire [5:0] last_event;
   wire [31:0] hrdata, intr_handler_addr, fetch_addr, ret_data, machine_state_reg;
   int err_count = 0, samples_checked = 0, resv = 0;
   event_vector_unit #(.vector_base_param(base), .reset_intr_enable_init(1),
      .reset_icache_on_init(1), .reset_fault_enable_init(1)) dut (.hclk, .hresetn, .hsel,
      .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .sys_reset, .dbg_reset, .fault_req, .fault_is_xlat,
      .fault_in_delay_slot, .fault_resume_pc(pc), .fault_next_pc(pc + 32'h4),
      .fault_data_addr(pc), .nm_break_req, .break_req, .break_return_pc(pc + 32'h8),
      .intr_req, .intr_return_pc(pc + 32'hC), .intr_handler_addr, .user_exc_req,
      .user_ret_sel, .user_return_pc(pc + 32'h10), .reserve_set, .redirect, .fetch_addr,
      .flush, .kill_execute, .ret_we, .ret_sel, .ret_data, .use_branch_target,
      .reserve_flag, .machine_state_reg, .last_event);
   event_source_model #(.handler(hnd)) far (.hclk, .hresetn, .intr_cmd, .rst_cmd,
      .sys_reset, .dbg_reset, .intr_req, .intr_handler_addr);
   // ****************
   // helpers
   // ****************
   initial begin
      forever #5 hclk = ~hclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one single-word transfer; waits are bounded since ready is never assumed
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      for (int ph = 0; ph < 2; ph++) begin
         n = 0;
         do begin
            @(posedge hclk);
            n++;
         end while (hreadyout !== 1'b1 && n < 40);
         if (n >= 40) begin
            err_count++;
            close_out();
         end
         if (ph == 0) begin
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
         end
      end
      rd = hrdata;
   endtask
   // ****************
   // scenarios
   // ****************
   initial begin
      int w;
      logic [31:0] r;
      logic bt;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk(fetch_addr, base);
      chk(machine_state_reg, ms_img);
      bus(1'b1, 32'h40, 32'hFFFF_FFFF);
      bus(1'b1, `A_FADDR, 32'h1234_5678);
      for (int a = 8; a <= 64; a += 4) begin
         bus(1'b0, a, 32'h0);
         chk(rd, 32'h0);
      end
      $display("test power_up done");
      // system and debugger reset each held with lower events pending
      for (int k = 1; k <= 2; k++) begin
         for (int a = 16; a <= 28; a += 4) bus(1'b1, a, xs());
         bus(1'b1, `A_STATE, 32'h0000_0FF0);
         @(posedge hclk);
         rst_cmd <= k[1:0];
         fault_req <= 1'b1;
         intr_cmd <= 1'b1;
         reserve_set <= 1'b1;
         @(posedge hclk);
         rst_cmd <= 2'h0;
         #1;
         for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (i == 15) begin
               fault_req <= 1'b0;
               intr_cmd <= 1'b0;
               reserve_set <= 1'b0;
            end
            #1;
            chk(last_event, `EV_RESET);
            chk(fetch_addr, base);
            chk(ret_we, 1'b0);
            chk(reserve_flag, 1'b0);
         end
         for (int a = 8; a <= 28; a += 4) begin
            bus(1'b0, a, 32'h0);
            chk(rd, 32'h0);
         end
         bus(1'b0, `A_STATE, 32'h0);
         chk(rd, ms_img);
      end
      $display("test reset_sources done");
      // random mixes of pending events against the priority model
      for (int i = 0; i < 60; i++) begin
         r = xs();
         @(posedge hclk);
         {user_exc_req, intr_cmd, break_req, nm_break_req, fault_req} <= r[4:0];
         fault_is_xlat <= r[5];
         fault_in_delay_slot <= r[6];
         reserve_set <= r[7];
         user_ret_sel <= r[12:8];
         pc <= {r[31:2], 2'h0};
         @(posedge hclk);
         {user_exc_req, intr_cmd, break_req, nm_break_req, fault_req} <= 5'h00;
         reserve_set <= 1'b0;
         #1;
         w = 0;
         while (w < 5 && !r[w]) w++;
         resv = (w < 5) ? 0 : (r[7] ? 1 : resv);
         bt = (w == 0) && !r[5] && r[6];
         if (w == 0) begin
            ds = bt;
         end
         chk(reserve_flag, resv);
         chk(redirect, w < 5);
         if (w < 5) begin
            chk(last_event, 6'h01 << (w + 1));
            chk(fetch_addr, base + ofs[w]);
            chk(kill_execute, w == 0);
            chk(use_branch_target, bt);
            chk(ret_we, !bt);
            if (!bt) begin
               chk(ret_sel, (w == 4) ? r[12:8] : rsel[w]);
               chk(ret_data, pc + 4 * ((w == 0) ? !r[5] : (w == 1) ? 2 : w));
            end
         end
      end
      bus(1'b0, `A_FSTAT, 32'h0);
      chk(rd, 32'(ds) << `DS_BIT);
      $display("test priority_mix done");
      // low-latency mode takes the controller's handler address
      bus(1'b1, `A_CTRL, 32'h1);
      @(posedge hclk);
      intr_cmd <= 1'b1;
      @(posedge hclk);
      intr_cmd <= 1'b0;
      #1;
      chk(fetch_addr, hnd);
      chk(ret_sel, `RET_INTR);
      bus(1'b1, `A_CTRL, 32'h0);
      bus(1'b0, `A_LAST, 32'h0);
      chk(rd, `EV_INTR);
      $display("test low_latency done");
      close_out();
   end
endmodule // event_vector_unit_tb
